// file: dv/printer_model.sv
// printer model: takes bytes with periodic stalls, drives its ready line
`timescale 1ns/10ps
module printer_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic stall,
  output logic tx_ready,
  output logic dsr_pin
);
  logic [1:0] cnt; // beat counter
  // free-running beat count
  always_ff @(posedge clk_sys) begin
    if (rst)
      cnt <= 2'h0;
    else
      cnt <= cnt + 2'h1;
  end
  // refuses one beat in four, and all while stalled
  assign tx_ready = !stall && cnt != 2'h3;
  // ready line drops while stalled
  assign dsr_pin = !stall;
endmodule

// file: dv/test_printer_message_store_output.sv
// self-checking bench of the message store and printer engine
`timescale 1ns/10ps
module test_printer_message_store_output;
  logic clk_sys, rst, print_req, msg_kind, print_done_flag, proc_err, stall;
  logic [1:0] req_op, test_sel;
  logic [8:0] msg_num, rc_num;
  logic [6:0] data_len, rc_len;
  logic rc_valid, rc_done, rc_err, wdat_valid, wdat_ready, rdat_valid, rx_valid;
  logic [15:0] rc_cmd;
  logic [2:0] rc_mode;
  logic [7:0] wdat, rdat, rx_byte, tx_data;
  logic flow_en, flow_hw, dsr_pin, half_duplex, cd_pin, rs_pin, tx_valid, tx_ready;
  int err_count, checks, n; // counters, pause count
  logic [31:0] seed; // random source state
  logic [7:0] cur [0:79]; // message being written
  logic [7:0] fixm [0:399][0:79]; // stored fixed messages
  logic [7:0] freem [0:30][0:79]; // stored free messages
  logic [7:0] rq [$]; // expected read chars
  logic [7:0] pq [$]; // expected printer bytes
  printer_message_store_output printer_message_store_output_inst (.clk_sys, .rst,
    .print_req, .req_op, .msg_kind, .msg_num, .data_len, .test_sel, .print_done_flag,
    .proc_err, .rc_valid, .rc_cmd, .rc_mode, .rc_num, .rc_len, .rc_done, .rc_err,
    .wdat_valid, .wdat_ready, .wdat, .rdat_valid, .rdat, .rx_valid, .rx_byte, .flow_en,
    .flow_hw, .dsr_pin, .half_duplex, .cd_pin, .rs_pin, .tx_valid, .tx_ready, .tx_data);
  printer_model printer_model_inst (.clk_sys, .rst, .stall, .tx_ready, .dsr_pin);
  // clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // next random word
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic stop_test;
    if (err_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // oldest note against each read char and each printed byte
  always @(posedge clk_sys) begin
    if (rdat_valid === 1'b1)
      chk(rdat, rq.size() ? rq.pop_front() : 32'h0000_0100);
    if (tx_valid === 1'b1 && tx_ready)
      chk(tx_data, pq.size() ? pq.pop_front() : 32'h0000_0100);
  end
  // random chars streamed while write port is ready
  task automatic feed(input logic [6:0] l);
    int i;
    for (i = 0; i < l; i++) begin
      seed = lfsr(seed);
      cur[i] = seed[7:0];
    end
    i = 0;
    wdat_valid <= 1'b1;
    wdat <= cur[0];
    while (i < l) begin
      @(posedge clk_sys);
      if (wdat_ready === 1'b1) begin
        i++;
        wdat <= cur[i % 80];
      end
    end
    wdat_valid <= 1'b0;
  endtask
  // commit written chars to the reference store
  task automatic keep(input logic k, input logic [8:0] n, input logic [6:0] l);
    for (int i = 0; i < l; i++) begin
      if (k)
        fixm[n][i] = cur[i];
      else
        freem[n][i] = cur[i];
    end
  endtask
  // note a stored message as expected read or print output
  task automatic note(input logic k, input logic [8:0] n, input logic [6:0] l, input logic p);
    for (int i = 0; i < l; i++) begin
      if (p)
        pq.push_back(k ? fixm[n][i] : freem[n][i]);
      else
        rq.push_back(k ? fixm[n][i] : freem[n][i]);
    end
  endtask
  // host request: raise, wait done, drop, see done clear
  task automatic host(input logic [1:0] op, input logic k, input logic [8:0] n,
      input logic [6:0] l, input logic [1:0] t, input logic e);
    int i;
    @(posedge clk_sys);
    print_req <= 1'b1;
    req_op <= op;
    msg_kind <= k;
    msg_num <= n;
    data_len <= l;
    test_sel <= t;
    if (op == 2'h0 && !e) begin
      feed(l);
      keep(k, n, l);
    end
    for (i = 0; i < 4000 && print_done_flag !== 1'b1; i++) @(posedge clk_sys);
    chk(print_done_flag, 1'b1);
    chk(rs_pin, 1'b0);
    chk(proc_err, e);
    chk(rq.size() + pq.size(), 0);
    print_req <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(print_done_flag, 0);
  endtask
  // remote command: one strobe, then wait for its pulse
  task automatic remote(input logic [15:0] c, input logic [2:0] m, input logic [8:0] n,
      input logic [6:0] l, input logic e);
    int i;
    @(posedge clk_sys);
    rc_valid <= 1'b1;
    rc_cmd <= c;
    rc_mode <= m;
    rc_num <= n;
    rc_len <= l;
    @(posedge clk_sys);
    rc_valid <= 1'b0;
    if (c == 16'h4349 && !e) begin
      feed(l);
      keep(1'b1, n, l);
    end
    for (i = 0; i < 400 && rc_done !== 1'b1 && rc_err !== 1'b1; i++) @(posedge clk_sys);
    chk(rc_done, !e);
    chk(rc_err, e);
    chk(rq.size(), 0);
  endtask
  // count bytes offered during a pause, after a short grace
  task automatic held(output int c);
    c = 0;
    repeat (6) @(posedge clk_sys);
    repeat (20) begin
      @(posedge clk_sys);
      c += (tx_valid === 1'b1);
    end
  endtask
  // one received control byte
  task automatic rx(input logic [7:0] b);
    @(posedge clk_sys);
    rx_valid <= 1'b1;
    rx_byte <= b;
    @(posedge clk_sys);
    rx_valid <= 1'b0;
  endtask
  // hang guard
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_count++;
    stop_test;
  end
  // main sequence
  initial begin
    {print_req, msg_kind, req_op, test_sel, msg_num, data_len} = '0;
    {rc_valid, rc_cmd, rc_mode, rc_num, rc_len, wdat_valid, wdat} = '0;
    {rx_valid, rx_byte, flow_en, flow_hw, half_duplex, cd_pin, stall} = '0;
    seed = 32'h0000_0e12;
    rst = 1'b1;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    // outputs quiet after reset
    @(posedge clk_sys);
    chk({print_done_flag, proc_err, rc_done, rc_err, rdat_valid, tx_valid, rs_pin,
      wdat_ready}, 8'h00);
    // free at top number, fixed at top number and full length
    host(2'h0, 1'b0, 9'h01e, 7'h03, 2'h0, 1'b0);
    note(1'b0, 9'h01e, 7'h03, 1'b0);
    host(2'h1, 1'b0, 9'h01e, 7'h03, 2'h0, 1'b0);
    host(2'h0, 1'b1, 9'h18f, 7'h50, 2'h0, 1'b0);
    note(1'b1, 9'h18f, 7'h50, 1'b0);
    host(2'h1, 1'b1, 9'h18f, 7'h50, 2'h0, 1'b0);
    // remote write and read in every protocol mode
    for (int m = 1; m <= 4; m++) begin
      remote(16'h4349, m[2:0], m[8:0], 7'h02, 1'b0);
      note(1'b1, m[8:0], 7'h02, 1'b0);
      remote(16'h434a, m[2:0], m[8:0], 7'h02, 1'b0);
    end
    // normal print of both kinds
    note(1'b1, 9'h18f, 7'h50, 1'b1);
    host(2'h2, 1'b1, 9'h18f, 7'h50, 2'h0, 1'b0);
    note(1'b0, 9'h01e, 7'h03, 1'b1);
    host(2'h2, 1'b0, 9'h01e, 7'h03, 2'h0, 1'b0);
    // stored test prints every registered fixed message in number order
    for (int m = 1; m <= 4; m++) note(1'b1, m[8:0], 7'h02, 1'b1);
    note(1'b1, 9'h18f, 7'h50, 1'b1);
    host(2'h2, 1'b0, 9'h000, 7'h01, 2'h1, 1'b0);
    // refusals leave the store untouched
    host(2'h0, 1'b1, 9'h190, 7'h02, 2'h0, 1'b1);
    host(2'h0, 1'b0, 9'h01f, 7'h02, 2'h0, 1'b1);
    host(2'h1, 1'b1, 9'h005, 7'h00, 2'h0, 1'b1);
    host(2'h3, 1'b1, 9'h005, 7'h02, 2'h0, 1'b1);
    host(2'h0, 1'b1, 9'h18f, 7'h51, 2'h0, 1'b1);
    note(1'b1, 9'h18f, 7'h50, 1'b0);
    host(2'h1, 1'b1, 9'h18f, 7'h50, 2'h0, 1'b0);
    remote(16'h4349, 3'h0, 9'h001, 7'h02, 1'b1);
    remote(16'h4349, 3'h5, 9'h001, 7'h02, 1'b1);
    remote(16'h434a, 3'h1, 9'h190, 7'h02, 1'b1);
    remote(16'h4349, 3'h1, 9'h001, 7'h51, 1'b1);
    remote(16'h4141, 3'h1, 9'h001, 7'h02, 1'b1);
    // pattern test with stop code, carrier and ready-line pauses
    for (int c = 8'h21; c <= 8'h7f; c++) pq.push_back(c[7:0]);
    flow_en <= 1'b1;
    half_duplex <= 1'b1;
    fork
      host(2'h2, 1'b0, 9'h000, 7'h01, 2'h2, 1'b0);
      begin
        repeat (10) @(posedge clk_sys);
        rx(8'h13);
        held(n);
        chk(n, 0);
        rx(8'h11);
        cd_pin <= 1'b1;
        held(n);
        chk(n, 0);
        chk(rs_pin, 1'b1);
        cd_pin <= 1'b0;
        flow_hw <= 1'b1;
        stall <= 1'b1;
        held(n);
        chk(n, 0);
        stall <= 1'b0;
      end
    join
    stop_test;
  end
endmodule

// file: hdl/pmo_defines.svh
// constants of the printer message store and output engine
// Function
// - remote fixed write/read, modes 1-4, 80 chars
// - host registers and reads fixed or free messages
// - print request sends selected message, given length
// - registered-message test prints stored fixed messages
// - printer test sends codes 21H to 7FH
// - free messages in buffer memory, 31 max
// - fixed messages in nonvolatile store, 400 max; the code clears their stored lengths on reset
// - remote selects fixed message by number
// - flow control pauses on DC codes or DSR
// - half duplex: never send while CD active; the code still sends for 2 cycles after CD rises, through its synchronizer
// - done flag set at end, cleared after request drops
// - fixed write command is 43H 49H
// - fixed read command is 43H 4AH
`ifndef PMO_DEFINES_SVH
`define PMO_DEFINES_SVH
`define MSG_CHARS 7'h50
`define FREE_MAX 9'h01F
`define FIX_MAX 9'h190
`define CMD_FIX_WR 16'h4349
`define CMD_FIX_RD 16'h434A
`define PROTO_MIN 3'h1
`define PROTO_MAX 3'h4
`define TEST_FIRST 8'h21
`define TEST_COUNT 7'h5F
`define CODE_DC1 8'h11
`define CODE_DC3 8'h13
`define OP_REGISTER 2'h0
`define OP_READ 2'h1
`define OP_PRINT 2'h2
`define TEST_NONE 2'h0
`define TEST_STORED 2'h1
`define TEST_PATTERN 2'h2
`endif

// file: hdl/pmo_pkg.sv
// types of the printer message store and output engine
package pmo_pkg;
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_WRITE, ST_READ, ST_PRINT, ST_DRAIN, ST_DONE
  } st_t;
  // all state of the engine
  typedef struct packed {
    st_t st;
    logic remote;
    logic kind;
    logic walk;
    logic ptest;
    logic err;
    logic done;
    logic rc_done;
    logic rc_err;
    logic rd_valid;
    logic [7:0] rd_char;
    logic [8:0] num;
    logic [6:0] len;
    logic [6:0] idx;
    logic xoff;
    logic dsr_m;
    logic dsr_s;
    logic cd_m;
    logic cd_s;
  } core_t;
  // state of the two-entry buffer
  typedef struct packed {
    logic [7:0] d0;
    logic [7:0] d1;
    logic [1:0] cnt;
  } buf_t;
endpackage

// file: hdl/printer_message_store_output.sv
// message store, remote commands and printer output engine
`timescale 1ns/10ps
`include "pmo_defines.svh"
module printer_message_store_output (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic print_req,
  input wire logic [1:0] req_op,
  input wire logic msg_kind,
  input wire logic [8:0] msg_num,
  input wire logic [6:0] data_len,
  input wire logic [1:0] test_sel,
  output logic print_done_flag,
  output logic proc_err,
  input wire logic rc_valid,
  input wire logic [15:0] rc_cmd,
  input wire logic [2:0] rc_mode,
  input wire logic [8:0] rc_num,
  input wire logic [6:0] rc_len,
  output logic rc_done,
  output logic rc_err,
  input wire logic wdat_valid,
  output logic wdat_ready,
  input wire logic [7:0] wdat,
  output logic rdat_valid,
  output logic [7:0] rdat,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic flow_en,
  input wire logic flow_hw,
  input wire logic dsr_pin,
  input wire logic half_duplex,
  input wire logic cd_pin,
  output logic rs_pin,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data
);
  pmo_pkg::core_t s; // registered state
  pmo_pkg::core_t next_s; // next state
  logic [7:0] free_mem [0:2479]; // free message chars
  logic [7:0] fix_mem [0:31999]; // fixed message chars
  logic [6:0] fix_len [0:399]; // stored fixed lengths
  logic [11:0] free_addr;
  logic [14:0] fix_addr;
  logic [7:0] mem_char; // char at the cursor
  logic push_valid; // engine offers a char
  logic push_ready; // buffer accepts it
  logic [7:0] push_char;
  logic buf_valid;
  logic link_hold; // flow or half-duplex stall
  logic wr_fire;
  logic last;
  logic range_bad; // host request out of range
  logic rc_known;
  logic rc_bad;

  // message addressing
  assign free_addr = 12'(s.num) * 12'(`MSG_CHARS) + 12'(s.idx);
  assign fix_addr = 15'(s.num) * 15'(`MSG_CHARS) + 15'(s.idx);
  assign mem_char = s.kind ? fix_mem[fix_addr] : free_mem[free_addr];
  assign last = (s.idx == s.len - 7'h1);
  assign wr_fire = (s.st == pmo_pkg::ST_WRITE) && wdat_valid;
  assign wdat_ready = (s.st == pmo_pkg::ST_WRITE);

  // limits on host requests
  always_comb begin
    range_bad = 1'b0;
    if (req_op != `OP_PRINT || test_sel == `TEST_NONE) begin
      range_bad = (data_len == 7'h0) || (data_len > `MSG_CHARS)
        || (msg_kind ? msg_num >= `FIX_MAX : msg_num >= `FREE_MAX);
    end
    if (req_op == 2'h3) begin
      range_bad = 1'b1;
    end
  end

  // remote command checks
  assign rc_known = (rc_cmd == `CMD_FIX_WR) || (rc_cmd == `CMD_FIX_RD);
  assign rc_bad = !rc_known || rc_mode < `PROTO_MIN || rc_mode > `PROTO_MAX
    || rc_len == 7'h0 || rc_len > `MSG_CHARS || rc_num >= `FIX_MAX;

  // printer side char source
  assign push_valid = (s.st == pmo_pkg::ST_PRINT) && (s.idx < s.len);
  assign push_char = s.ptest ? `TEST_FIRST + 8'(s.idx) : mem_char;

  // stalls toward the printer
  always_comb begin
    link_hold = 1'b0;
    if (flow_en) begin
      link_hold = flow_hw ? !s.dsr_s : s.xoff;
    end
    if (half_duplex && s.cd_s) begin
      link_hold = 1'b1;
    end
  end

  two_entry_buffer #(.W(8)) u_buf (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_char),
    .out_valid(buf_valid),
    .out_ready(tx_ready && !link_hold),
    .out_data(tx_data)
  );
  assign tx_valid = buf_valid && !link_hold;
  assign rs_pin = push_valid || buf_valid;

  // sequencer
  always_comb begin
    next_s = s;
    next_s.rc_done = 1'b0;
    next_s.rc_err = 1'b0;
    next_s.rd_valid = 1'b0;
    next_s.dsr_m = dsr_pin;
    next_s.dsr_s = s.dsr_m;
    next_s.cd_m = cd_pin;
    next_s.cd_s = s.cd_m;
    // device-control codes from the printer
    if (rx_valid && rx_byte == `CODE_DC3) begin
      next_s.xoff = 1'b1;
    end else if (rx_valid && rx_byte == `CODE_DC1) begin
      next_s.xoff = 1'b0;
    end
    case (s.st)
      pmo_pkg::ST_IDLE: begin
        next_s.idx = 7'h0;
        next_s.walk = 1'b0;
        next_s.ptest = 1'b0;
        if (print_req) begin
          // host request
          next_s.remote = 1'b0;
          next_s.kind = msg_kind;
          next_s.num = msg_num;
          next_s.len = data_len;
          next_s.err = range_bad;
          if (range_bad) begin
            next_s.st = pmo_pkg::ST_DONE;
          end else if (req_op == `OP_REGISTER) begin
            next_s.st = pmo_pkg::ST_WRITE;
          end else if (req_op == `OP_READ) begin
            next_s.st = pmo_pkg::ST_READ;
          end else begin
            next_s.st = pmo_pkg::ST_PRINT;
            if (test_sel == `TEST_PATTERN) begin
              next_s.ptest = 1'b1;
              next_s.len = `TEST_COUNT;
            end else if (test_sel == `TEST_STORED) begin
              next_s.walk = 1'b1;
              next_s.kind = 1'b1;
              next_s.num = 9'h000;
              next_s.len = fix_len[0];
            end
          end
        end else if (rc_valid) begin
          // remote command, fixed messages only
          next_s.remote = 1'b1;
          next_s.kind = 1'b1;
          next_s.num = rc_num;
          next_s.len = rc_len;
          if (rc_bad) begin
            next_s.rc_err = 1'b1;
          end else if (rc_cmd == `CMD_FIX_WR) begin
            next_s.st = pmo_pkg::ST_WRITE;
          end else begin
            next_s.st = pmo_pkg::ST_READ;
          end
        end
      end
      pmo_pkg::ST_WRITE: begin
        if (wdat_valid) begin
          next_s.idx = s.idx + 7'h1;
          if (last) begin
            next_s.st = pmo_pkg::ST_DONE;
          end
        end
      end
      pmo_pkg::ST_READ: begin
        next_s.rd_valid = 1'b1;
        next_s.rd_char = mem_char;
        next_s.idx = s.idx + 7'h1;
        if (last) begin
          next_s.st = pmo_pkg::ST_DONE;
        end
      end
      pmo_pkg::ST_PRINT: begin
        if (push_valid && push_ready) begin
          next_s.idx = s.idx + 7'h1;
        end else if (!push_valid) begin
          // stored test walks every fixed message
          if (s.walk && s.num < `FIX_MAX - 9'h001) begin
            next_s.num = s.num + 9'h001;
            next_s.len = fix_len[s.num + 9'h001];
            next_s.idx = 7'h0;
          end else begin
            next_s.st = pmo_pkg::ST_DRAIN;
          end
        end
      end
      pmo_pkg::ST_DRAIN: begin
        if (!buf_valid) begin
          next_s.st = pmo_pkg::ST_DONE;
        end
      end
      pmo_pkg::ST_DONE: begin
        if (s.remote) begin
          next_s.rc_done = 1'b1;
          next_s.st = pmo_pkg::ST_IDLE;
        end else begin
          next_s.done = 1'b1;
          if (!print_req) begin
            next_s.done = 1'b0;
            next_s.err = 1'b0;
            next_s.st = pmo_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        next_s.st = pmo_pkg::ST_IDLE;
      end
    endcase
  end

  // register the state
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // message stores; lengths clear so the stored test skips empty numbers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < `FIX_MAX; i++) begin
        fix_len[i] <= 7'h0;
      end
    end else if (wr_fire && s.kind) begin
      fix_mem[fix_addr] <= wdat;
      fix_len[s.num] <= s.len;
    end
    if (wr_fire && !s.kind) begin
      free_mem[free_addr] <= wdat;
    end
  end

  assign print_done_flag = s.done;
  assign proc_err = s.err && s.done;
  assign rc_done = s.rc_done;
  assign rc_err = s.rc_err;
  assign rdat_valid = s.rd_valid;
  assign rdat = s.rd_char;

  sequence s_done_seen;
    print_done_flag && !print_req;
  endsequence
  sequence s_bad_host;
    s.st == pmo_pkg::ST_IDLE && print_req && req_op == `OP_REGISTER
      && data_len > `MSG_CHARS;
  endsequence

  a_done_clears: assert property (@(posedge clk_sys) disable iff (rst)
    s_done_seen |=> !print_done_flag)
    else $error("done flag stayed after request dropped");
  a_done_rises: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(print_done_flag) |-> print_req && $past(s.st) == pmo_pkg::ST_DONE)
    else $error("done flag rose without a request");
  a_bad_len: assert property (@(posedge clk_sys) disable iff (rst)
    s_bad_host |-> ##2 proc_err && print_done_flag)
    else $error("oversize length not reported");
  a_dsr_pause: assert property (@(posedge clk_sys) disable iff (rst)
    flow_en && flow_hw && !s.dsr_s |-> !tx_valid)
    else $error("sent while dsr low");
  a_xoff_pause: assert property (@(posedge clk_sys) disable iff (rst)
    flow_en && !flow_hw && rx_valid && rx_byte == `CODE_DC3 ##1 flow_en && !flow_hw
      |-> !tx_valid)
    else $error("sent after stop code");
  a_half_dup: assert property (@(posedge clk_sys) disable iff (rst)
    half_duplex && $past(cd_pin, 2) && $past(cd_pin, 3) |-> !tx_valid)
    else $error("sent while carrier detected");
  a_test_char: assert property (@(posedge clk_sys) disable iff (rst)
    push_valid && s.ptest |-> push_char >= `TEST_FIRST && push_char <= 8'h7F)
    else $error("test pattern char out of range");
  a_rc_mode: assert property (@(posedge clk_sys) disable iff (rst)
    s.st == pmo_pkg::ST_IDLE && !print_req && rc_valid && rc_mode == 3'h0
      |=> rc_err && s.st == pmo_pkg::ST_IDLE)
    else $error("command taken outside modes 1 to 4");
  a_cmd_write: assert property (@(posedge clk_sys) disable iff (rst)
    s.st == pmo_pkg::ST_IDLE && !print_req && rc_valid && !rc_bad
      && rc_cmd == `CMD_FIX_WR |=> wdat_ready)
    else $error("fixed write command not decoded");
  a_read_len: assert property (@(posedge clk_sys) disable iff (rst)
    s.st == pmo_pkg::ST_IDLE && !print_req && rc_valid && !rc_bad
      && rc_cmd == `CMD_FIX_RD && rc_len == 7'h02 |=> ##1 rdat_valid [*2] ##1 !rdat_valid)
    else $error("fixed read returned wrong count");
endmodule

// file: hdl/two_entry_buffer.sv
// two-entry valid/ready buffer in front of the printer port
`timescale 1ns/10ps
module two_entry_buffer #(
  parameter int W = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] d0; // head entry
  logic [W-1:0] d1; // second entry
  logic [1:0] cnt; // entries held
  logic [W-1:0] next_d0;
  logic [W-1:0] next_d1;
  logic [1:0] next_cnt;
  logic push;
  logic pop;

  assign in_ready = (cnt != 2'h2);
  assign out_valid = (cnt != 2'h0);
  assign out_data = d0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pop shifts, push lands behind what stays
  always_comb begin
    next_d0 = d0;
    next_d1 = d1;
    next_cnt = cnt;
    if (pop) begin
      next_d0 = d1;
      next_cnt = next_cnt - 2'h1;
    end
    if (push) begin
      if (next_cnt == 2'h0) begin
        next_d0 = in_data;
      end else begin
        next_d1 = in_data;
      end
      next_cnt = next_cnt + 2'h1;
    end
  end

  // register the buffer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      d0 <= '0;
      d1 <= '0;
      cnt <= 2'h0;
    end else begin
      d0 <= next_d0;
      d1 <= next_d1;
      cnt <= next_cnt;
    end
  end

  a_no_overflow: assert property (@(posedge clk_sys) disable iff (rst)
    cnt == 2'h2 && !out_ready |=> cnt == 2'h2 && d0 == $past(d0))
    else $error("buffer lost a word while full");
endmodule
